/* File: sld_pkg.sv */
// Constants shared by the segment display driver: register map, field
// positions, reset values, prescaler and waveform level codes.
// Assumes one system clock; all values here are plain constants.
`default_nettype none

package sld_pkg;

    // Geometry
    localparam int NUM_FP = 40;
    localparam int NUM_BP = 4;
    localparam int MEM_BYTES = 20;
    localparam int SEG_BITS = 160;

    // Register bus widths
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [4:0] OFS_CTRL0 = 5'h00;
    localparam logic [4:0] OFS_CTRL1 = 5'h01;
    localparam logic [4:0] OFS_FPEN_FIRST = 5'h02;
    localparam logic [4:0] OFS_FPEN_LAST = 5'h06;
    localparam logic [4:0] OFS_STATUS = 5'h07;
    localparam logic [4:0] OFS_MEM_FIRST = 5'h08;
    localparam logic [4:0] OFS_MEM_LAST = 5'h1b;

    // Control 0 fields
    localparam int CTRL0_ON_BIT = 7;
    localparam int CTRL0_PRE_LSB = 4;
    localparam int CTRL0_BIAS_BIT = 2;
    localparam int CTRL0_DUTY_LSB = 0;
    // Control 1 fields
    localparam int CTRL1_HALT_BIT = 0;
    // Status fields
    localparam int STAT_RUN_BIT = 7;
    localparam int STAT_POL_BIT = 6;

    // Reset values: 1/4 duty, display off, all frontplanes off
    localparam logic [7:0] CTRL0_RESET = 8'h00;
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    localparam logic [39:0] FPEN_RESET = 40'h00_0000_0000;

    // Duty codes
    localparam logic [1:0] DUTY_1_4 = 2'h0;
    localparam logic [1:0] DUTY_1_1 = 2'h1;
    localparam logic [1:0] DUTY_1_2 = 2'h2;
    localparam logic [1:0] DUTY_1_3 = 2'h3;

    // Effective bias codes for the analog level generator
    localparam logic [1:0] BIAS_1_1 = 2'h1;
    localparam logic [1:0] BIAS_1_2 = 2'h2;
    localparam logic [1:0] BIAS_1_3 = 2'h3;

    // Prescaler: smallest divider minus one; the divider doubles per code step
    localparam logic [8:0] DIV_BASE_LAST = 9'h03f;

    // Pin level codes V0 (driver ground) to V3 (display supply)
    localparam logic [1:0] LVL_V0 = 2'h0;
    localparam logic [1:0] LVL_V1 = 2'h1;
    localparam logic [1:0] LVL_V2 = 2'h2;
    localparam logic [1:0] LVL_V3 = 2'h3;

    // Pin drive state
    typedef enum logic [2:0] {
        DRV_OFF = 3'b001,
        DRV_RUN = 3'b010,
        DRV_GND = 3'b100
    } sld_drive_t;

endpackage

`default_nettype wire

/* File: sld_driver.sv */
// Segment display driver: register port, segment memory, prescaler,
// backplane and frontplane waveform generation with low-power handling.
// Assumes the source clock input, wait and stop flags are synchronous
// to sys_clk; the analog stage turns level codes into voltages.
//
// Summary of operation
// - Prescale code 00..11 divides source clock by 64, 128, 256, 512.
// - One frame lasts as many display clock periods as active backplanes.
// - Segment memory holds 160 bits, one per frontplane/backplane crossing.
// - Bit 1 drives ON waveform when display on and frontplane enabled.
// - Bit 0 drives the OFF waveform combination.
// - Bus reads and writes memory anytime while waveforms read it too.
// - With display off the memory is plain CPU storage.
// - Touching the display-on bit never changes memory contents.
// - Memory is not initialised by reset.
// - Enabled frontplane stays silent until display-on is set.
// - With display on, a frontplane starts as soon as it is enabled.
// - Backplane waveforms repeat every two frames, independent of memory.
// - Frontplane waveform uses that frontplane's bit per active phase.
// - Duty 01=1/1, 10=1/2, 11=1/3, 00=1/4 select active backplanes.
// - Unused backplanes are held high impedance.
// - Bias 1/1 at 1/1 duty; bias bit at 1/2; 1/3 bias otherwise.
// - Halt-in-wait clear: waveforms continue unchanged in wait mode.
// - Halt-in-wait set: clocks stop in wait, enabled pins go to ground.
// - Memory and registers keep their values through wait mode.
// - Stop mode stops clocks, grounds enabled pins, keeps state.
// - After stop, clocks resume if display on; pins restore function.
// - 1/1 duty drives backplane 0 only; 1/2 duty backplanes 0 and 1.
// - Reset gives 1/4 duty, 1/3 bias, all enables off, pins hi-Z.
`timescale 1ns/1ps
`default_nettype none

module sld_driver
    import sld_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // Clock source and power modes
    input wire logic display_source_clock,
    input wire logic wait_mode,
    input wire logic stop_mode,
    // Analog stage
    output logic [1:0] bias_mode,
    // Backplane pins: level code and output enable (low = driven)
    output logic [2*NUM_BP-1:0] backplane_out,
    output logic [NUM_BP-1:0] backplane_oe_n,
    // Frontplane pins: level code and output enable (low = driven)
    output logic [2*NUM_FP-1:0] frontplane_out,
    output logic [NUM_FP-1:0] frontplane_oe_n
);

    // Last phase index for a duty code
    function automatic logic [1:0] last_phase(input logic [1:0] duty);
        unique case (duty)
            DUTY_1_1: last_phase = 2'h0;
            DUTY_1_2: last_phase = 2'h1;
            DUTY_1_3: last_phase = 2'h2;
            DUTY_1_4: last_phase = 2'h3;
        endcase
    endfunction

    // Registers
    logic [7:0] display_control_0;
    logic [7:0] display_control_1;
    logic [NUM_FP-1:0] frontplane_enable;
    // Segment memory, no reset on purpose
    logic [7:0] seg_mem [MEM_BYTES];

    // Waveform state
    logic src_q;
    logic [8:0] pre_cnt;
    logic disp_tick;
    logic [1:0] phase;
    logic polarity;

    // Field views
    wire display_on = display_control_0[CTRL0_ON_BIT];
    wire [1:0] display_prescale_sel =
        display_control_0[CTRL0_PRE_LSB+:2];
    wire bias_bit = display_control_0[CTRL0_BIAS_BIT];
    wire [1:0] duty_sel = display_control_0[CTRL0_DUTY_LSB+:2];
    wire duty_select_hi = duty_sel[1];
    wire duty_select_lo = duty_sel[0];
    wire halt_in_wait = display_control_1[CTRL1_HALT_BIT];

    // Address decode
    wire hit_ctrl0 = reg_addr == OFS_CTRL0;
    wire hit_ctrl1 = reg_addr == OFS_CTRL1;
    wire hit_fpen = reg_addr >= OFS_FPEN_FIRST &&
        reg_addr <= OFS_FPEN_LAST;
    wire hit_status = reg_addr == OFS_STATUS;
    wire hit_mem = reg_addr >= OFS_MEM_FIRST && reg_addr <= OFS_MEM_LAST;
    wire [2:0] fpen_idx = 3'(reg_addr - OFS_FPEN_FIRST);
    wire [4:0] mem_idx = reg_addr - OFS_MEM_FIRST;

    // Low-power gating; in either case registers simply hold
    wire halted = stop_mode || (wait_mode && halt_in_wait);
    wire running = display_on && !halted;

    // Prescaler terminal count: 64 << code, minus one
    wire [9:0] div_len = ({1'b0, DIV_BASE_LAST} + 10'h001) <<
        display_prescale_sel;
    wire [8:0] div_last = 9'(div_len - 10'h001);
    wire src_rise = display_source_clock && !src_q;
    wire [1:0] phase_last = last_phase({duty_select_hi, duty_select_lo});

    // Effective bias
    wire [1:0] next_bias_mode =
        (duty_sel == DUTY_1_1) ? BIAS_1_1 :
        (duty_sel == DUTY_1_2 && !bias_bit) ? BIAS_1_2 : BIAS_1_3;

    // Drive state shared by all enabled pins
    sld_drive_t drive_state;
    assign drive_state = !display_on ? DRV_OFF :
        (halted ? DRV_GND : DRV_RUN);

    // Status readback
    wire [7:0] status_val = {running, polarity, 4'h0, phase};

    wire [7:0] fpen_byte = frontplane_enable[8*fpen_idx+:8];
    wire [7:0] next_rdata =
        !reg_rd ? 8'h00 :
        hit_ctrl0 ? display_control_0 :
        hit_ctrl1 ? display_control_1 :
        hit_fpen ? fpen_byte :
        hit_status ? status_val :
        hit_mem ? seg_mem[mem_idx] : 8'h00;

    // Register writes; the memory is a separate array
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            display_control_0 <= CTRL0_RESET;
            display_control_1 <= CTRL1_RESET;
            frontplane_enable <= FPEN_RESET;
        end
        else if (reg_wr)
        begin
            if (hit_ctrl0)
                display_control_0 <= reg_wdata & 8'hb7;
            if (hit_ctrl1)
                display_control_1 <= reg_wdata & 8'h01;
            if (hit_fpen)
                frontplane_enable[8*fpen_idx+:8] <= reg_wdata;
        end
    end

    // Segment memory port; waveform logic reads it concurrently
    always_ff @(posedge sys_clk)
    begin
        if (reg_wr && hit_mem)
            seg_mem[mem_idx] <= reg_wdata;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= next_rdata;
    end

    // Prescaler; frozen while halted so wait/stop resume seamlessly
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            src_q <= 1'b0;
            pre_cnt <= 9'h000;
            disp_tick <= 1'b0;
        end
        else
        begin
            src_q <= display_source_clock;
            disp_tick <= 1'b0;
            if (!display_on)
                pre_cnt <= 9'h000;
            else if (running && src_rise)
            begin
                if (pre_cnt >= div_last)
                begin
                    pre_cnt <= 9'h000;
                    disp_tick <= 1'b1;
                end
                else
                    pre_cnt <= pre_cnt + 9'h001;
            end
        end
    end

    // Phase counter and frame polarity
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase <= 2'h0;
            polarity <= 1'b0;
        end
        else if (!display_on)
        begin
            phase <= 2'h0;
            polarity <= 1'b0;
        end
        else if (disp_tick && running)
        begin
            if (phase >= phase_last)
            begin
                phase <= 2'h0;
                polarity <= !polarity;
            end
            else
                phase <= phase + 2'h1;
        end
    end

    // Backplane pins
    logic [2*NUM_BP-1:0] next_bp_out;
    logic [NUM_BP-1:0] next_bp_oe_n;
    always_comb
    begin
        next_bp_out = '0;
        next_bp_oe_n = '1;
        for (int j = 0; j < NUM_BP; j++)
        begin
            if (2'(j) <= phase_last)
            begin
                unique case (drive_state)
                    DRV_OFF:
                        next_bp_oe_n[j] = 1'b1;
                    DRV_GND:
                    begin
                        next_bp_oe_n[j] = 1'b0;
                        next_bp_out[2*j+:2] = LVL_V0;
                    end
                    DRV_RUN:
                    begin
                        next_bp_oe_n[j] = 1'b0;
                        if (2'(j) == phase)
                            next_bp_out[2*j+:2] = polarity ? LVL_V0 : LVL_V3;
                        else
                            next_bp_out[2*j+:2] = polarity ? LVL_V2 : LVL_V1;
                    end
                endcase
            end
        end
    end

    // Frontplane pins: bit for frontplane i, backplane p sits in
    // byte i/2 at bit 4*(i%2)+p
    logic [2*NUM_FP-1:0] next_fp_out;
    logic [NUM_FP-1:0] next_fp_oe_n;
    always_comb
    begin
        logic [7:0] seg_byte;
        logic seg_on;
        seg_byte = 8'h00;
        seg_on = 1'b0;
        next_fp_out = '0;
        next_fp_oe_n = '1;
        for (int i = 0; i < NUM_FP; i++)
        begin
            seg_byte = seg_mem[i/2];
            seg_on = seg_byte[4*(i%2) + int'(phase)];
            if (frontplane_enable[i])
            begin
                unique case (drive_state)
                    DRV_OFF:
                        next_fp_oe_n[i] = 1'b1;
                    DRV_GND:
                    begin
                        next_fp_oe_n[i] = 1'b0;
                        next_fp_out[2*i+:2] = LVL_V0;
                    end
                    DRV_RUN:
                    begin
                        next_fp_oe_n[i] = 1'b0;
                        if (seg_on)
                            next_fp_out[2*i+:2] = polarity ? LVL_V3 : LVL_V0;
                        else
                            next_fp_out[2*i+:2] = polarity ? LVL_V1 : LVL_V2;
                    end
                endcase
            end
        end
    end

    // Pin registers; outputs come straight from flops
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            backplane_out <= '0;
            backplane_oe_n <= '1;
            frontplane_out <= '0;
            frontplane_oe_n <= '1;
            bias_mode <= BIAS_1_3;
        end
        else
        begin
            backplane_out <= next_bp_out;
            backplane_oe_n <= next_bp_oe_n;
            frontplane_out <= next_fp_out;
            frontplane_oe_n <= next_fp_oe_n;
            bias_mode <= next_bias_mode;
        end
    end

endmodule

`default_nettype wire

/* File: sld_glass.sv */
// Passive glass model: frontplanes 0 and 1 against all four backplanes.
// Assumes level codes 0..3 and output enables that are low when driven.
`timescale 1ns/1ps
`default_nettype none

module sld_glass
(
    // Clock and clear
    input wire logic sys_clk,
    input wire logic clr,
    // Pins
    input wire logic [7:0] bp_lvl,
    input wire logic [3:0] bp_oe_n,
    input wire logic [3:0] fp_lvl,
    input wire logic [1:0] fp_oe_n,
    // Segments seen at full drive, bit 4*fp+bp, one flag per sign
    output logic [7:0] lit_pos,
    output logic [7:0] lit_neg
);
    // Only full-swing differences light a segment; floating pins never do
    always @(posedge sys_clk)
    begin
        for (int k = 0; k < 8; k++)
        begin
            if (clr)
            begin
                lit_pos[k] <= 1'b0;
                lit_neg[k] <= 1'b0;
            end
            else if (!fp_oe_n[k / 4] && !bp_oe_n[k % 4])
            begin
                if ({fp_lvl[2 * (k / 4) +: 2], bp_lvl[2 * (k % 4) +: 2]} == 4'hc)
                    lit_pos[k] <= 1'b1;
                if ({fp_lvl[2 * (k / 4) +: 2], bp_lvl[2 * (k % 4) +: 2]} == 4'h3)
                    lit_neg[k] <= 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

/* File: sld_driver_props.sv */
// Port checker for the segment display driver.
// Assumes it is bound to sld_driver and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module sld_driver_props
    import sld_pkg::*;
(
    // Clock, reset and register port
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    // Source clock, power modes and pins
    input wire logic display_source_clock,
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire logic [1:0] bias_mode,
    input wire logic [2*NUM_BP-1:0] backplane_out,
    input wire logic [NUM_BP-1:0] backplane_oe_n,
    input wire logic [2*NUM_FP-1:0] frontplane_out,
    input wire logic [NUM_FP-1:0] frontplane_oe_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    logic [7:0] c0;
    logic [7:0] c0_d;
    logic c1;
    logic [10:0] gap;
    logic [10:0] calm;
    logic lp;
    logic [3:0] used;
    logic [1:0] exp_bias;

    assign lp = stop_mode | (wait_mode & c1);
    assign used = (c0_d[1:0] == DUTY_1_1) ? 4'h1 :
        (c0_d[1:0] == DUTY_1_2) ? 4'h3 :
        (c0_d[1:0] == DUTY_1_3) ? 4'h7 : 4'hf;
    assign exp_bias = (c0[1:0] == DUTY_1_1) ? BIAS_1_1 :
        (c0[1:0] != DUTY_1_2 || c0[CTRL0_BIAS_BIT]) ? BIAS_1_3 : BIAS_1_2;

    // Shadow control bytes; c0_d is what the pins reflect
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            c0 <= CTRL0_RESET;
            c0_d <= CTRL0_RESET;
            c1 <= 1'b0;
        end
        else
        begin
            if (reg_wr && reg_addr == OFS_CTRL0)
                c0 <= reg_wdata;
            if (reg_wr && reg_addr == OFS_CTRL1)
                c1 <= reg_wdata[CTRL1_HALT_BIT];
            c0_d <= c0;
        end
    end

    // Gap between backplane changes, trusted only if nothing disturbed it
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gap <= 11'h000;
            calm <= 11'h000;
        end
        else
        begin
            gap <= $changed(backplane_out) ? 11'h000 :
                gap + {10'h000, gap < 11'h7d0};
            calm <= (reg_wr || lp || !c0_d[CTRL0_ON_BIT]) ? 11'h000 :
                calm + {10'h000, calm < 11'h7d0};
        end
    end

    a_read_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_unmapped_read: assert property (reg_rd && reg_addr > OFS_MEM_LAST
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_off_hiz: assert property (!c0_d[CTRL0_ON_BIT]
        |-> &frontplane_oe_n && &backplane_oe_n) else $error("pin driven off");
    a_unused_bp: assert property ((backplane_oe_n | used) == 4'hf)
        else $error("unused backplane driven");
    a_used_bp: assert property (c0_d[CTRL0_ON_BIT]
        |-> (backplane_oe_n & used) == 4'h0) else $error("backplane floats");
    a_bias_map: assert property (c0 == c0_d
        |=> bias_mode == $past(exp_bias)) else $error("bias mode wrong");
    a_lowpower_gnd: assert property (lp |=>
        (backplane_out[1:0] == LVL_V0 || backplane_oe_n[0]) &&
        (frontplane_out[1:0] == LVL_V0 || frontplane_oe_n[0]))
        else $error("enabled pin not grounded");
    a_tick_gap: assert property ($changed(backplane_out)
        && calm > gap + 11'h004 |-> gap >= (11'h080 << c0_d[5:4]) - 11'h002)
        else $error("backplane phase too short");
endmodule

bind sld_driver sld_driver_props u_props (.sys_clk, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .display_source_clock,
    .wait_mode, .stop_mode, .bias_mode, .backplane_out, .backplane_oe_n,
    .frontplane_out, .frontplane_oe_n);

`default_nettype wire

/* File: sld_driver_tb.sv */
// Self-checking bench for the segment display driver.
// Assumes the glass model and the bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none

module sld_driver_tb;
    import sld_pkg::*;

    logic sys_clk;
    logic rst_n;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic display_source_clock;
    logic wait_mode;
    logic stop_mode;
    logic [1:0] bias_mode;
    logic [2*NUM_BP-1:0] backplane_out;
    logic [NUM_BP-1:0] backplane_oe_n;
    logic [2*NUM_FP-1:0] frontplane_out;
    logic [NUM_FP-1:0] frontplane_oe_n;
    logic clr;
    logic [7:0] lit_pos;
    logic [7:0] lit_neg;
    int n_fail;
    int check_count;

    sld_driver DUT (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .display_source_clock, .wait_mode, .stop_mode,
        .bias_mode, .backplane_out, .backplane_oe_n, .frontplane_out,
        .frontplane_oe_n);
    sld_glass glass (.sys_clk, .clr, .bp_lvl(backplane_out),
        .bp_oe_n(backplane_oe_n), .fp_lvl(frontplane_out[3:0]),
        .fp_oe_n(frontplane_oe_n[1:0]), .lit_pos, .lit_neg);

    always #5 sys_clk = ~sys_clk;
    // Source at half the system rate: one phase is 128 << prescale cycles
    always @(posedge sys_clk)
        display_source_clock <= ~display_source_clock;

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
        logic [7:0] v;
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
        chk("rdata", e, v);
    endtask

    task automatic lit_chk(input int n, input logic [7:0] e);
        @(posedge sys_clk);
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        cyc(n);
        chk("lit_pos", e, lit_pos);
        chk("lit_neg", e, lit_neg);
    endtask

    task automatic t_reset;
        cyc(1);
        chk("bp_oe", 8'h0f, {4'h0, backplane_oe_n});
        chk("bias", {6'h00, BIAS_1_3}, {6'h00, bias_mode});
        rdchk(OFS_CTRL0, CTRL0_RESET);
        rdchk(OFS_FPEN_LAST, 8'h00);
        rdchk(OFS_STATUS, 8'h00);
        $display("reset test done");
    endtask

    task automatic t_mem;
        for (int i = 0; i < MEM_BYTES; i++)
            wr(OFS_MEM_FIRST + 5'(i), 8'(i * 37 + 5));
        wr(OFS_CTRL0, 8'h80);
        for (int i = 0; i < MEM_BYTES; i++)
            rdchk(OFS_MEM_FIRST + 5'(i), 8'(i * 37 + 5));
        wr(OFS_CTRL0, 8'h00);
        wr(5'h1c, 8'hff);
        rdchk(5'h1c, 8'h00);
        $display("memory test done");
    endtask

    task automatic t_duty(input logic [1:0] d, input logic [1:0] pre,
        input logic b, input logic [3:0] used, input logic [1:0] eb);
        wr(OFS_CTRL0, {1'b1, 1'b0, pre, 1'b0, b, d});
        lit_chk((2 * $countones(used) + 1) * (128 << pre),
            8'h96 & {used, used});
        chk("bias", {6'h00, eb}, {6'h00, bias_mode});
        chk("bp_oe", {4'h0, ~used}, {4'h0, backplane_oe_n});
        wr(OFS_CTRL0, 8'h00);
        $display("duty test done");
    endtask

    task automatic t_seq;
        wr(OFS_FPEN_FIRST, 8'h01);
        cyc(2);
        chk("fp_oe", 8'h03, {6'h00, frontplane_oe_n[1:0]});
        wr(OFS_CTRL0, 8'h80);
        cyc(1);
        chk("fp_oe", 8'h02, {6'h00, frontplane_oe_n[1:0]});
        wr(OFS_FPEN_FIRST, 8'h03);
        cyc(1);
        chk("fp_oe", 8'h00, {6'h00, frontplane_oe_n[1:0]});
        // Last frontplane: its memory bit for backplane 0 is clear
        wr(OFS_FPEN_LAST, 8'h80);
        cyc(1);
        chk("fp39_oe", 8'h00, {7'h00, frontplane_oe_n[39]});
        chk("fp39_lvl", 8'h02, {6'h00, frontplane_out[79:78]});
        rdchk(OFS_STATUS, 8'h80);
        $display("sequencing test done");
    endtask

    task automatic t_low;
        wr(OFS_CTRL1, 8'h01);
        @(posedge sys_clk);
        wait_mode <= 1'b1;
        cyc(3);
        chk("fp_lvl", 8'h00, {6'h00, frontplane_out[1:0]});
        chk("bp_lvl", 8'h00, {6'h00, backplane_out[1:0]});
        chk("fp39_lvl", 8'h00, {6'h00, frontplane_out[79:78]});
        rdchk(OFS_MEM_FIRST, 8'h96);
        rdchk(OFS_CTRL1, 8'h01);
        @(posedge sys_clk);
        wait_mode <= 1'b0;
        stop_mode <= 1'b1;
        cyc(3);
        chk("fp_oe", 8'h00, {6'h00, frontplane_oe_n[1:0]});
        chk("fp_lvl", 8'h00, {6'h00, frontplane_out[1:0]});
        @(posedge sys_clk);
        stop_mode <= 1'b0;
        wr(OFS_CTRL1, 8'h00);
        @(posedge sys_clk);
        wait_mode <= 1'b1;
        lit_chk(9 * 128, 8'h96);
        @(posedge sys_clk);
        wait_mode <= 1'b0;
        $display("low power test done");
    endtask

    task automatic results;
        $display("Checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        display_source_clock = 1'b0;
        wait_mode = 1'b0;
        stop_mode = 1'b0;
        clr = 1'b0;
        n_fail = 0;
        check_count = 0;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_mem();
        wr(OFS_MEM_FIRST, 8'h96);
        wr(OFS_FPEN_FIRST, 8'h03);
        t_duty(DUTY_1_1, 2'h3, 1'b1, 4'h1, BIAS_1_1);
        t_duty(DUTY_1_2, 2'h2, 1'b0, 4'h3, BIAS_1_2);
        t_duty(DUTY_1_2, 2'h1, 1'b1, 4'h3, BIAS_1_3);
        t_duty(DUTY_1_3, 2'h1, 1'b0, 4'h7, BIAS_1_3);
        t_duty(DUTY_1_4, 2'h0, 1'b1, 4'hf, BIAS_1_3);
        t_seq();
        t_low();
        results();
    end

    initial
    begin
        repeat (100000) @(posedge sys_clk);
        n_fail++;
        results();
    end
endmodule

`default_nettype wire
